// ---- verilog/sfwp_consts.svh ----
// Opcodes, status bit positions, field widths and timing constants
`ifndef SFWP_CONSTS_SVH
`define SFWP_CONSTS_SVH
`define SFWP_OP_WRITE_ENABLE_CMD_CODE 8'h06
`define SFWP_OP_WRITE_DISABLE_CMD_CODE 8'h04
`define SFWP_OP_ARM_CODE 8'h50
`define SFWP_OP_SWR_CODE 8'h01
`define SFWP_OP_SRD_CODE 8'h05
`define SFWP_OP_JID_CODE 8'h9f
`define SFWP_OP_LID_A_CODE 8'h90
`define SFWP_OP_LID_B_CODE 8'hab
`define SFWP_ST_BUSY 0
`define SFWP_ST_WEL 1
`define SFWP_ST_BP_LO 2
`define SFWP_ST_BP_HI 5
`define SFWP_ST_AAI 6
`define SFWP_ST_LOCK 7
`define SFWP_STATUS_RST 8'h00
`define SFWP_WRITE_MASK 8'hbc
`define SFWP_ADDR_BITS 24
`define SFWP_OPC_BITS 8
`define SFWP_LID_DATA_BIT 32
`define SFWP_BP_TIME_US 10
`define SFWP_CLK_MHZ 250
`define SFWP_BP_CYCLES (`SFWP_BP_TIME_US * `SFWP_CLK_MHZ)
`endif

// ---- verilog/sfwp_pkg.sv ----
// Types shared by the write-protect and id command block
package sfwp_pkg;
  typedef enum logic [4:0] {
    SFWP_IDLE = 5'h01,
    SFWP_OPC = 5'h02,
    SFWP_DATA = 5'h04,
    SFWP_OUT = 5'h08,
    SFWP_SKIP = 5'h10
  } sfwp_state_t;
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } sfwp_pins_t;
endpackage

// ---- verilog/sfwp_core.sv ----
// SPI flash command logic: write enable, status write protection, id reads
//
// What this block does
// - Write-enable sets the write-enable latch flag
// - Status write clears the latch flag at end
// - Commands act only at chip-enable rising edge
// - Write-disable clears latch and auto-increment flags
// - Write-disable leaves running program to finish
// - Status-arm opens status register for one write
// - Status write changes only protect and lock
// - Locked with pin low ignores status writes
// - Pin low lets lock go only up
// - Pin high makes all protect bits writable
// - Unlocked write may set lock and protects together
// - Id command 9F returns maker, type, capacity
// - Chip-enable rising ends id output anytime
// - Legacy id alternates maker and capacity codes
// - Write-disable opcode is 04
// - Status register readable at any time
`timescale 1ns/1ps
`include "sfwp_consts.svh"
module sfwp_core #(
  parameter logic [7:0] MAKER_CODE = 8'h5a,  // Arbitrary value
  parameter logic [7:0] TYPE_CODE = 8'h11,  // Arbitrary value
  parameter logic [7:0] CAP_CODE = 8'h22,  // Arbitrary value
  parameter int BP_CYCLES = `SFWP_BP_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_wp_n,
  input wire logic i_prog_active,
  input wire logic i_aai_set,
  output logic o_miso,
  output logic o_miso_oe,
  output logic [7:0] o_status,
  output logic o_prog_allowed
);
  logic [2:0] cs_sync_reg, sck_sync_reg, mosi_sync_reg, wp_sync_reg;
  sfwp_pkg::sfwp_pins_t pin_s;
  logic cs_prev_reg, sck_prev_reg;
  logic sck_rise, sck_fall, cs_rise, cs_fall;
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      cs_sync_reg <= 3'h7;
      sck_sync_reg <= 3'h0;
      mosi_sync_reg <= 3'h0;
      wp_sync_reg <= 3'h0;
      cs_prev_reg <= 1'b1;
      sck_prev_reg <= 1'b0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], i_cs_n};
      sck_sync_reg <= {sck_sync_reg[1:0], i_sck};
      mosi_sync_reg <= {mosi_sync_reg[1:0], i_mosi};
      wp_sync_reg <= {wp_sync_reg[1:0], i_wp_n};
      cs_prev_reg <= pin_s.cs_n;
      sck_prev_reg <= pin_s.sck;
    end
  end
  assign pin_s = '{cs_n: cs_sync_reg[1], sck: sck_sync_reg[1], mosi: mosi_sync_reg[1]};
  assign sck_rise = pin_s.sck & ~sck_prev_reg & ~pin_s.cs_n;
  assign sck_fall = ~pin_s.sck & sck_prev_reg & ~pin_s.cs_n;
  assign cs_rise = pin_s.cs_n & ~cs_prev_reg;
  assign cs_fall = ~pin_s.cs_n & cs_prev_reg;

  // Local names for the package's state codes; nothing is imported
  localparam sfwp_pkg::sfwp_state_t SFWP_IDLE = sfwp_pkg::SFWP_IDLE;
  localparam sfwp_pkg::sfwp_state_t SFWP_OPC = sfwp_pkg::SFWP_OPC;
  localparam sfwp_pkg::sfwp_state_t SFWP_DATA = sfwp_pkg::SFWP_DATA;
  localparam sfwp_pkg::sfwp_state_t SFWP_OUT = sfwp_pkg::SFWP_OUT;
  localparam sfwp_pkg::sfwp_state_t SFWP_SKIP = sfwp_pkg::SFWP_SKIP;
  sfwp_pkg::sfwp_state_t state_reg, state_next;
  logic [7:0] opc_reg, opc_next, data_reg, data_next, sr_reg, sr_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [7:0] shout_reg, shout_next;
  logic [1:0] idx_reg, idx_next;
  logic armed_reg, armed_next, miso_reg, miso_next, oe_reg, oe_next;
  logic busy_reg, busy_next;
  logic [$clog2(BP_CYCLES+1)-1:0] tail_reg, tail_next;
  logic [7:0] sw_val;
  logic sw_ok;
  logic [7:0] op_sh;

  function automatic logic [7:0] id_byte(input logic [1:0] i, input logic legacy);
    if (legacy) begin
      id_byte = i[0] ? CAP_CODE : MAKER_CODE;
    end else begin
      unique case (i)
        2'h0: id_byte = MAKER_CODE;
        2'h1: id_byte = TYPE_CODE;
        default: id_byte = CAP_CODE;
      endcase
    end
  endfunction

  always_comb begin
    state_next = state_reg;
    opc_next = opc_reg;
    data_next = data_reg;
    sr_next = sr_reg;
    cnt_next = cnt_reg;
    shout_next = shout_reg;
    idx_next = idx_reg;
    armed_next = armed_reg;
    miso_next = miso_reg;
    oe_next = oe_reg;
    busy_next = busy_reg;
    tail_next = tail_reg;
    op_sh = {opc_reg[6:0], pin_s.mosi};
    // Lock with pin low: write ignored; else only protects and lock taken
    sw_ok = !(~wp_sync_reg[1] & sr_reg[`SFWP_ST_LOCK]);
    sw_val = (sr_reg & ~`SFWP_WRITE_MASK) | (data_reg & `SFWP_WRITE_MASK);
    // Running program keeps busy for one byte-program time after disable
    if (tail_reg != '0) begin
      tail_next = tail_reg - 1'b1;
    end
    busy_next = i_prog_active | (tail_reg != '0);
    sr_next[`SFWP_ST_BUSY] = busy_next;
    if (cs_fall) begin
      state_next = SFWP_OPC;
      cnt_next = '0;
    end
    unique case (state_reg)
      SFWP_IDLE: ;
      SFWP_OPC: begin
        if (sck_rise) begin
          opc_next = op_sh;
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == 6'(`SFWP_OPC_BITS - 1)) begin
            cnt_next = '0;
            idx_next = '0;
            if (op_sh == `SFWP_OP_SWR_CODE) begin
              state_next = SFWP_DATA;
            end else if (op_sh == `SFWP_OP_SRD_CODE) begin
              state_next = SFWP_OUT;
              shout_next = sr_next;
            end else if (op_sh == `SFWP_OP_JID_CODE) begin
              state_next = SFWP_OUT;
              shout_next = id_byte(2'h0, 1'b0);
            end else if (op_sh == `SFWP_OP_LID_A_CODE || op_sh == `SFWP_OP_LID_B_CODE) begin
              state_next = SFWP_DATA;
            end else begin
              state_next = SFWP_SKIP;
            end
          end
        end
      end
      SFWP_DATA: begin
        if (sck_rise) begin
          data_next = {data_reg[6:0], pin_s.mosi};
          cnt_next = cnt_reg + 6'h01;
          if (opc_reg != `SFWP_OP_SWR_CODE && cnt_reg == 6'(`SFWP_ADDR_BITS - 1)) begin
            state_next = SFWP_OUT;
            idx_next = {1'b0, pin_s.mosi};
            shout_next = id_byte({1'b0, pin_s.mosi}, 1'b1);
            cnt_next = '0;
          end
        end
      end
      SFWP_OUT: begin
        if (sck_fall) begin
          oe_next = 1'b1;
          miso_next = shout_reg[7];
          shout_next = {shout_reg[6:0], 1'b0};
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg[2:0] == 3'h7) begin
            if (opc_reg == `SFWP_OP_SRD_CODE) begin
              shout_next = sr_reg;
            end else if (opc_reg == `SFWP_OP_JID_CODE) begin
              idx_next = (idx_reg == 2'h2) ? 2'h2 : idx_reg + 2'h1;
              shout_next = (idx_reg == 2'h2) ? 8'h00 : id_byte(idx_reg + 2'h1, 1'b0);
            end else begin
              idx_next = {1'b0, ~idx_reg[0]};
              shout_next = id_byte({1'b0, ~idx_reg[0]}, 1'b1);
            end
          end
        end
      end
      SFWP_SKIP: ;
      default: state_next = SFWP_IDLE;
    endcase
    if (cs_rise) begin
      state_next = SFWP_IDLE;
      oe_next = 1'b0;
      miso_next = 1'b0;
      // Commands take effect only here, and only when fully shifted
      if (state_reg == SFWP_SKIP) begin
        if (opc_reg == `SFWP_OP_WRITE_ENABLE_CMD_CODE) begin
          sr_next[`SFWP_ST_WEL] = 1'b1;
          armed_next = 1'b0;
        end else if (opc_reg == `SFWP_OP_WRITE_DISABLE_CMD_CODE) begin
          sr_next[`SFWP_ST_WEL] = 1'b0;
          sr_next[`SFWP_ST_AAI] = 1'b0;
          armed_next = 1'b0;
          if (i_prog_active) begin
            tail_next = ($bits(tail_reg))'(BP_CYCLES);
          end
        end else if (opc_reg == `SFWP_OP_ARM_CODE) begin
          armed_next = 1'b1;
        end else begin
          armed_next = 1'b0;
        end
      end else if (state_reg == SFWP_DATA && opc_reg == `SFWP_OP_SWR_CODE &&
                   cnt_reg == 6'(`SFWP_OPC_BITS)) begin
        if ((armed_reg | sr_reg[`SFWP_ST_WEL]) && sw_ok) begin
          sr_next[7:2] = sw_val[7:2];
        end
        sr_next[`SFWP_ST_WEL] = 1'b0;
        armed_next = 1'b0;
      end else if (state_reg != SFWP_IDLE) begin
        armed_next = 1'b0;
      end
    end
    // Set after the disable so a same-cycle set from the array wins
    if (i_aai_set) begin
      sr_next[`SFWP_ST_AAI] = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      state_reg <= SFWP_IDLE;
      opc_reg <= 8'h00;
      data_reg <= 8'h00;
      sr_reg <= `SFWP_STATUS_RST;
      cnt_reg <= 6'h00;
      shout_reg <= 8'h00;
      idx_reg <= 2'h0;
      armed_reg <= 1'b0;
      miso_reg <= 1'b0;
      oe_reg <= 1'b0;
      busy_reg <= 1'b0;
      tail_reg <= '0;
    end else begin
      state_reg <= state_next;
      opc_reg <= opc_next;
      data_reg <= data_next;
      sr_reg <= sr_next;
      cnt_reg <= cnt_next;
      shout_reg <= shout_next;
      idx_reg <= idx_next;
      armed_reg <= armed_next;
      miso_reg <= miso_next;
      oe_reg <= oe_next;
      busy_reg <= busy_next;
      tail_reg <= tail_next;
    end
  end

  // Program and erase gating is the outer array logic's job
  logic allow_reg;
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      allow_reg <= 1'b0;
    end else begin
      allow_reg <= sr_next[`SFWP_ST_WEL];
    end
  end
  assign o_miso = miso_reg;
  assign o_miso_oe = oe_reg;
  assign o_status = sr_reg;
  assign o_prog_allowed = allow_reg;

  chk_write_enable_cmd_sets_latch: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    cs_rise && state_reg == SFWP_SKIP && opc_reg == `SFWP_OP_WRITE_ENABLE_CMD_CODE
    |=> sr_reg[`SFWP_ST_WEL]) else $error("latch not set");
  chk_write_disable_cmd_clears: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    cs_rise && state_reg == SFWP_SKIP && opc_reg == `SFWP_OP_WRITE_DISABLE_CMD_CODE
    |=> !sr_reg[`SFWP_ST_WEL] && !sr_reg[`SFWP_ST_AAI]) else $error("flags kept");
  chk_latch_edge_only: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $rose(sr_reg[`SFWP_ST_WEL]) |-> $past(cs_rise)) else $error("latch mid frame");
  chk_swr_clears_wel: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    cs_rise && state_reg == SFWP_DATA && opc_reg == `SFWP_OP_SWR_CODE
    |=> !sr_reg[`SFWP_ST_WEL]) else $error("latch not cleared");
  chk_lock_holds: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    sr_reg[`SFWP_ST_LOCK] && !wp_sync_reg[1] && !wp_sync_reg[2]
    |=> $stable(sr_reg[7:2]) || $past(i_aai_set) || $past(opc_reg) == `SFWP_OP_WRITE_DISABLE_CMD_CODE)
    else $error("locked bits moved");
  chk_wp_lock_up: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $fell(sr_reg[`SFWP_ST_LOCK]) |-> $past(wp_sync_reg[1])) else $error("lock cleared");
  chk_id_end: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    cs_rise |=> !o_miso_oe && state_reg == SFWP_IDLE) else $error("output kept");
  chk_busy_tail: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    tail_reg != '0 |=> sr_reg[`SFWP_ST_BUSY]) else $error("busy dropped");
  chk_sw_mask: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    cs_rise && state_reg == SFWP_DATA && opc_reg == `SFWP_OP_SWR_CODE
    |=> sr_reg[`SFWP_ST_AAI] == $past(sr_reg[`SFWP_ST_AAI]) || $past(i_aai_set))
    else $error("aai written");
  cov_write_enable_cmd: cover property (@(posedge i_sys_clk) $rose(sr_reg[`SFWP_ST_WEL]));
  cov_lock: cover property (@(posedge i_sys_clk) $rose(sr_reg[`SFWP_ST_LOCK]));
  cov_jid: cover property (@(posedge i_sys_clk)
    state_reg == SFWP_OUT && opc_reg == `SFWP_OP_JID_CODE && idx_reg == 2'h2);
  cov_lid: cover property (@(posedge i_sys_clk)
    state_reg == SFWP_OUT && opc_reg == `SFWP_OP_LID_A_CODE && idx_reg == 2'h1);
endmodule

// ---- tb/sfwp_host.sv ----
// Host side SPI master model for the flash command pins
`timescale 1ns/1ps
module sfwp_host (
  input wire logic i_sys_clk,
  input wire logic i_miso,
  output sfwp_pkg::sfwp_pins_t o_pins
);
  initial begin
    o_pins = '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // Mode 0, MSB first; clock stands low between frames
  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    o_pins.cs_n = 1'b0;
    wait_clk(4);
    for (int i = n - 1; i >= 0; i--) begin
      o_pins.mosi = tx[i];
      wait_clk(4);
      rx = {rx[62:0], i_miso};
      o_pins.sck = 1'b1;
      wait_clk(4);
      o_pins.sck = 1'b0;
    end
    wait_clk(4);
    o_pins.cs_n = 1'b1;
    // Released line must not keep the last bit
    o_pins.mosi = ~o_pins.mosi;
    wait_clk(10);
  endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the write-protect and id command logic
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
  localparam logic [7:0] TYPE = 8'h4e; // Arbitrary value
  localparam logic [7:0] CAP = 8'h71; // Arbitrary value
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wp_n = 1'b1;
  logic prog = 1'b0;
  logic auto_increment_program_flag = 1'b0;
  logic miso;
  logic miso_oe;
  logic prog_ok;
  logic [7:0] status;
  logic [7:0] exp_st = 8'h00;
  logic [63:0] rx;
  logic [31:0] lid;
  sfwp_pkg::sfwp_pins_t pins;
  int fail_count = 0;
  int checks = 0;
  sfwp_host host (.i_sys_clk(clk), .i_miso(miso), .o_pins(pins));
  sfwp_core #(.MAKER_CODE(MAKER), .TYPE_CODE(TYPE), .CAP_CODE(CAP), .BP_CYCLES(8)) dut (
    .i_sys_clk(clk), .i_nrst(nrst), .i_cs_n(pins.cs_n), .i_sck(pins.sck),
    .i_mosi(pins.mosi), .i_wp_n(wp_n), .i_prog_active(prog), .i_aai_set(auto_increment_program_flag),
    .o_miso(miso), .o_miso_oe(miso_oe), .o_status(status), .o_prog_allowed(prog_ok));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic finish_test();
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    host.frame({56'h0, op}, 8, rx);
  endtask
  // Kind 0 latch, 1 arm, 2 bare, 3 arm broken by another command
  task automatic status_write(input int kind, input logic [7:0] d, input logic wp);
    logic ok;
    wp_n = wp;
    if (kind == 0) begin
      cmd(8'h06);
      exp_st[1] = 1'b1;
    end
    if (kind == 1 || kind == 3) cmd(8'h50);
    if (kind == 3) host.frame(64'h9f000000, 32, rx);
    ok = exp_st[1] || kind == 1;
    host.frame({48'h0, 8'h01, d}, 16, rx);
    if (ok && !(!wp && exp_st[7])) exp_st = (exp_st & 8'h41) | (d & 8'hbc);
    exp_st[1] = 1'b0;
    check(32'(status), 32'(exp_st));
  endtask
  function automatic logic [31:0] legacy_exp(input logic a0);
    return a0 ? {CAP, MAKER, CAP, MAKER} : {MAKER, CAP, MAKER, CAP};
  endfunction
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial begin
    void'($urandom(66));
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check(32'({status, prog_ok, miso_oe, miso}), 32'h0);
    // Power-up settling before the first frame
    repeat (2500) @(negedge clk);
    cmd(8'h06);
    check(32'({status, prog_ok}), 32'h005);
    prog = 1'b1;
    auto_increment_program_flag = 1'b1;
    @(negedge clk);
    auto_increment_program_flag = 1'b0;
    repeat (6) @(negedge clk);
    check(32'(status), 32'h43);
    host.frame({40'h0, 8'h05, 16'h0}, 24, rx);
    check(rx[31:0], 32'h4343);
    cmd(8'h04);
    check(32'({status, prog_ok}), 32'h002);
    prog = 1'b0;
    repeat (20) @(negedge clk);
    check(32'(status), 32'h00);
    exp_st = 8'h00;
    status_write(0, 8'hff, 1'b0);
    status_write(0, 8'h00, 1'b0);
    status_write(1, 8'h00, 1'b1);
    for (int k = 0; k < 24; k++) begin
      status_write(int'($urandom_range(3, 0)), 8'($urandom), 1'($urandom));
    end
    host.frame(64'h9f000000, 32, rx);
    check(rx[31:0], {8'h0, MAKER, TYPE, CAP});
    host.frame(64'h9f000, 20, rx);
    check(32'({rx[11:0], miso_oe}), 32'({MAKER, TYPE[7:4], 1'b0}));
    for (int k = 0; k < 4; k++) begin
      host.frame({k[1] ? 8'hab : 8'h90, 23'h0, k[0], 32'h0}, 64, rx);
      lid = legacy_exp(k[0]);
      check(rx[31:0], lid);
    end
    finish_test();
  end
endmodule
